// ===== include/pulse_counter_regs.svh
// Register offsets, field positions and timing counts of the pulse counter.
// Assumes an 8-bit register port with a 4-bit address.
`ifndef PULSE_COUNTER_REGS_SVH
`define PULSE_COUNTER_REGS_SVH

`define ADDR_W          4
`define OFF_MODE        4'h0
`define OFF_PUCFG       4'h1
`define OFF_CNT0        4'h2
`define OFF_CNT1        4'h5
`define OFF_THR0        4'h8
`define OFF_THR1        4'hB
`define OFF_STAT        4'hE
`define OFF_WAKE_EN     4'hF
`define OFF_CNT0_B1     4'h3
`define OFF_CNT0_B2     4'h4
`define OFF_CNT1_B1     4'h6
`define OFF_CNT1_B2     4'h7
`define OFF_THR0_B1     4'h9
`define OFF_THR0_B2     4'hA
`define OFF_THR1_B1     4'hC
`define OFF_THR1_B2     4'hD
`define PUCFG_WMASK     8'h3F

`define MODE_CNT_HI     7
`define MODE_CNT_LO     6
`define MODE_RATE_HI    5
`define MODE_RATE_LO    4
`define PU_CALGO_BIT    6
`define PU_CALPORT_BIT  5
`define PU_STR_HI       4
`define PU_STR_LO       2
`define PU_DUTY_HI      1
`define PU_DUTY_LO      0

`define ST_OVF0         0
`define ST_OVF1         1
`define ST_CMP0         2
`define ST_CMP1         3
`define ST_CAL_BUSY     4
`define ST_CAL_FAIL     5

`define MODE_RESET      8'h00
`define PUCFG_RESET     8'h00
`define STR_MAX         3'h7
`define STR_FIRST       3'h1

// Sample period in RTC clock edges at 32.768 kHz: 250 us is 8 edges
`define RATE_BASE_TICKS 7'h08
`define INTEG_MAX       4'hF
`define INTEG_W         4

`endif

// ===== include/pulse_counter_pkg.sv
// Types shared by the pulse counter modules.
// No assumptions beyond a SystemVerilog compiler.
package pulse_counter_pkg;
   typedef enum logic [1:0] {MODE_OFF, MODE_SINGLE, MODE_DUAL, MODE_QUAD} count_mode_t;
   typedef enum logic {CAL_IDLE, CAL_TEST} cal_state_t;
endpackage

// ===== rtl/debounce_integrator.sv
// Saturating up/down integrator used as a switch debouncer.
// Assumes a synchronised input and a one-cycle step strobe.
`timescale 1ns/100ps
`include "pulse_counter_regs.svh"
module debounce_integrator
   import pulse_counter_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic step,
   input  wire logic hold,
   input  wire logic din,
   output logic      level_q
);
   logic [`INTEG_W-1:0] acc_q;
   logic [`INTEG_W-1:0] acc_d;
   logic                level_d;

   always_comb begin
      acc_d   = acc_q;
      level_d = level_q;
      if (step && !hold) begin
         if (din && acc_q != `INTEG_MAX)
            acc_d = acc_q + `INTEG_W'(1);
         else if (!din && acc_q != '0)
            acc_d = acc_q - `INTEG_W'(1);
         // Hysteresis: output only flips at the rails
         if (acc_d == `INTEG_MAX)
            level_d = 1'b1;
         else if (acc_d == '0)
            level_d = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_q   <= '0;
         level_q <= 1'b0;
      end else begin
         acc_q   <= acc_d;
         level_q <= level_d;
      end
   end
endmodule // debounce_integrator

// ===== rtl/quadrature_decoder.sv
// Two-bit quadrature step decoder producing clockwise and counter-clockwise pulses.
// Assumes debounced inputs that change only around the step strobe.
`timescale 1ns/100ps
module quadrature_decoder (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic step,
   input  wire logic in_one,
   input  wire logic in_zero,
   output logic      cw_q,
   output logic      ccw_q
);
   logic [1:0] prev_q;
   logic [1:0] prev_d;
   logic       cw_d;
   logic       ccw_d;
   logic [1:0] cur;

   always_comb begin
      cur    = {in_one, in_zero};
      prev_d = prev_q;
      cw_d   = 1'b0;
      ccw_d  = 1'b0;
      if (step) begin
         prev_d = cur;
         unique case ({prev_q, cur})
            4'h1, 4'h7, 4'hE, 4'h8: ccw_d = 1'b1;
            4'h2, 4'hB, 4'hD, 4'h4: cw_d = 1'b1;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_q <= 2'h0;
         cw_q   <= 1'b0;
         ccw_q  <= 1'b0;
      end else begin
         prev_q <= prev_d;
         cw_q   <= cw_d;
         ccw_q  <= ccw_d;
      end
   end
endmodule // quadrature_decoder

// ===== rtl/pulse_counter.sv
// Low-power pulse counter: two 24-bit counters, threshold compare, pull-up control.
// Assumes an RTC clock pin slower than clk and switch inputs from pins.
// Operation
// - Two independent 24-bit counters count qualified input transitions.
// - Counters only increment, wrapping from all ones to zero.
// - Counter overflow can raise a wake-up event.
// - Per-counter 24-bit comparator can wake on reaching its threshold.
// - Sampling, debounce and pull-up timing come from the RTC clock.
// - Counting enabled only when mode bits 7:6 select single, dual, quadrature.
// - Any write to the mode register clears both counters.
// - Software cannot write the counters; they are read only.
// - Single mode: input zero drives counter 0 only.
// - Dual mode: each input its own counter; shared pull-up settings.
// - Quadrature: clockwise increments counter 0, counter-clockwise counter 1.
// - Counter-clockwise sequence LL, LH, HH, HL with input 1 first.
// - Printed clockwise sequence repeats a state; resolved elsewhere.
// - Pull-ups have selectable strength and duty cycle.
// - Calibration finds the weakest strength that reaches a valid high.
// - Sample interval 250 us, 500 us, 1 ms or 2 ms from RTC.
// - During calibration integrators hold and counters do not increment.
// - Each input passes a digital debounce integrator.
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "pulse_counter_regs.svh"
module pulse_counter
   import pulse_counter_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              rtc_clk,
   input  wire logic              pulse_input_zero,
   input  wire logic              pulse_input_one,
   input  wire logic [`ADDR_W-1:0] addr,
   input  wire logic [7:0]        wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [7:0]        rdata_q,
   output logic                   wake_q,
   output logic                   pullup_en_q,
   output logic      [2:0]        pullup_str_q
);
   // Pin synchronisers; stage one is read only by stage two
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic       rtc_prev_q;
   logic       rtc_edge;
   logic       in0_s;
   logic       in1_s;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_q    <= 3'h0;
         sync2_q    <= 3'h0;
         rtc_prev_q <= 1'b0;
      end else begin
         sync1_q    <= {rtc_clk, pulse_input_one, pulse_input_zero};
         sync2_q    <= sync1_q;
         rtc_prev_q <= sync2_q[2];
      end
   end

   assign rtc_edge = sync2_q[2] & ~rtc_prev_q;
   assign in0_s    = sync2_q[0];
   assign in1_s    = sync2_q[1];

   // Registers
   logic [7:0]  mode_q;
   logic [7:0]  mode_d;
   logic [7:0]  pucfg_q;
   logic [7:0]  pucfg_d;
   logic [23:0] thr_q [2];
   logic [23:0] thr_d [2];
   logic [3:0]  wake_en_q;
   logic [3:0]  wake_en_d;
   logic        mode_wr;
   count_mode_t mode;
   logic [1:0]  rate;

   assign mode_wr = wr && addr == `OFF_MODE;
   assign mode    = count_mode_t'(mode_q[`MODE_CNT_HI:`MODE_CNT_LO]);
   assign rate    = mode_q[`MODE_RATE_HI:`MODE_RATE_LO];

   // Sample timing from RTC edges
   logic [6:0] ph_q;
   logic [6:0] ph_d;
   logic [6:0] period;
   logic [6:0] on_len;
   logic [9:0] on_prod;
   logic       sample_tick;
   logic       step_q;
   logic       pu_on;

   always_comb begin
      // 8, 16, 32 or 64 RTC edges
      period = `RATE_BASE_TICKS << rate;
      unique case (pucfg_q[`PU_DUTY_HI:`PU_DUTY_LO])
         2'h0: on_prod = {3'h0, period} << 1;
         2'h1: on_prod = ({3'h0, period} << 1) + {3'h0, period};
         2'h2: on_prod = {3'h0, period} << 2;
         2'h3: on_prod = ({3'h0, period} << 2) + ({3'h0, period} << 1);
      endcase
      // duty in eighths of the period
      on_len      = on_prod[9:3];
      ph_d        = ph_q;
      sample_tick = 1'b0;
      if (rtc_edge) begin
         if (ph_q >= period - 7'h01) begin
            ph_d        = 7'h00;
            sample_tick = 1'b1;
         end else begin
            ph_d = ph_q + 7'h01;
         end
      end
      // Pull-up charges the wire just before the sample
      pu_on = ph_q >= period - on_len;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph_q   <= 7'h00;
         step_q <= 1'b0;
      end else begin
         ph_q   <= ph_d;
         step_q <= sample_tick;
      end
   end

   // Calibration and register writes
   cal_state_t cal_q;
   cal_state_t cal_d;
   logic [2:0] cal_str_q;
   logic [2:0] cal_str_d;
   logic       cal_fail_set;
   logic       cal_in;
   logic       pu_en_d;
   logic [2:0] pu_str_d;

   always_comb begin
      mode_d       = mode_q;
      pucfg_d      = pucfg_q;
      thr_d        = thr_q;
      wake_en_d    = wake_en_q;
      cal_d        = cal_q;
      cal_str_d    = cal_str_q;
      cal_fail_set = 1'b0;
      cal_in       = pucfg_q[`PU_CALPORT_BIT] ? in1_s : in0_s;
      if (wr) begin
         unique case (addr)
            `OFF_MODE:     mode_d = wdata;
            `OFF_PUCFG:    pucfg_d = {1'b0, wdata[6:0]} & `PUCFG_WMASK;
            `OFF_THR0:     thr_d[0][7:0] = wdata;
            `OFF_THR0_B1:  thr_d[0][15:8] = wdata;
            `OFF_THR0_B2:  thr_d[0][23:16] = wdata;
            `OFF_THR1:     thr_d[1][7:0] = wdata;
            `OFF_THR1_B1:  thr_d[1][15:8] = wdata;
            `OFF_THR1_B2:  thr_d[1][23:16] = wdata;
            `OFF_WAKE_EN:  wake_en_d = wdata[3:0];
            default: ;
         endcase
      end
      unique case (cal_q)
         CAL_IDLE: begin
            if (wr && addr == `OFF_PUCFG && wdata[`PU_CALGO_BIT]) begin
               cal_d     = CAL_TEST;
               cal_str_d = `STR_FIRST;
            end
         end
         CAL_TEST: begin
            if (sample_tick) begin
               if (cal_in) begin
                  pucfg_d[`PU_STR_HI:`PU_STR_LO] = cal_str_q;
                  cal_d = CAL_IDLE;
               end else if (cal_str_q == `STR_MAX) begin
                  cal_fail_set = 1'b1;
                  cal_d        = CAL_IDLE;
               end else begin
                  cal_str_d = cal_str_q + 3'h1;
               end
            end
         end
      endcase
      pu_str_d = (cal_q == CAL_TEST) ? cal_str_q : pucfg_q[`PU_STR_HI:`PU_STR_LO];
      // Strength zero means pull-up disabled
      pu_en_d  = (pu_str_d != 3'h0) && ((cal_q == CAL_TEST) || pu_on);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_q       <= `MODE_RESET;
         pucfg_q      <= `PUCFG_RESET;
         thr_q[0]     <= 24'h000000;
         thr_q[1]     <= 24'h000000;
         wake_en_q    <= 4'h0;
         cal_q        <= CAL_IDLE;
         cal_str_q    <= 3'h0;
         pullup_en_q  <= 1'b0;
         pullup_str_q <= 3'h0;
      end else begin
         mode_q       <= mode_d;
         pucfg_q      <= pucfg_d;
         thr_q        <= thr_d;
         wake_en_q    <= wake_en_d;
         cal_q        <= cal_d;
         cal_str_q    <= cal_str_d;
         pullup_en_q  <= pu_en_d;
         pullup_str_q <= pu_str_d;
      end
   end

   // Debounce, shared settings for both inputs
   logic deb0;
   logic deb1;
   logic deb_prev_q [2];
   logic cw_q;
   logic ccw_q;
   logic cal_hold;

   assign cal_hold = cal_q == CAL_TEST;

   // both channels share one integrator setup
   debounce_integrator u_deb0 (
      .clk     (clk),
      .rst     (rst),
      .step    (sample_tick),
      .hold    (cal_hold),
      .din     (in0_s),
      .level_q (deb0)
   );

   debounce_integrator u_deb1 (
      .clk     (clk),
      .rst     (rst),
      .step    (sample_tick),
      .hold    (cal_hold),
      .din     (in1_s),
      .level_q (deb1)
   );

   quadrature_decoder u_quad (
      .clk     (clk),
      .rst     (rst),
      .step    (step_q),
      .in_one  (deb1),
      .in_zero (deb0),
      .cw_q    (cw_q),
      .ccw_q   (ccw_q)
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         deb_prev_q[0] <= 1'b0;
         deb_prev_q[1] <= 1'b0;
      end else if (step_q) begin
         deb_prev_q[0] <= deb0;
         deb_prev_q[1] <= deb1;
      end
   end

   // Increment selection per mode; quadrature pulses arrive one cycle later
   logic [1:0] inc;
   logic [1:0] rise;

   always_comb begin
      rise[0] = step_q & deb0 & ~deb_prev_q[0];
      rise[1] = step_q & deb1 & ~deb_prev_q[1];
      inc     = 2'b00;
      if (!cal_hold) begin
         unique case (mode)
            MODE_OFF:    inc = 2'b00;
            MODE_SINGLE: inc = {1'b0, rise[0]};
            MODE_DUAL:   inc = rise;
            // cw to 0, ccw to 1
            MODE_QUAD:   inc = {ccw_q, cw_q};
         endcase
      end
   end

   // Counters and comparators, one per channel
   logic [1:0] ovf_ev;
   logic [1:0] cmp_ev;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         logic [23:0] cnt_q;
         logic [23:0] cnt_d;
         logic        ovf_d;
         logic        cmp_d;

         always_comb begin
            cnt_d = cnt_q;
            ovf_d = 1'b0;
            cmp_d = 1'b0;
            if (mode_wr) begin
               cnt_d = 24'h000000;
            end else if (inc[ch]) begin
               cnt_d = cnt_q + 24'h000001;
               ovf_d = cnt_q == 24'hFFFFFF;
               cmp_d = cnt_d == thr_q[ch];
            end
         end

         always_ff @(posedge clk or posedge rst) begin
            if (rst)
               cnt_q <= 24'h000000;
            else
               cnt_q <= cnt_d;
         end

         assign ovf_ev[ch] = ovf_d;
         assign cmp_ev[ch] = cmp_d;
      end
   endgenerate

   // Status flags: write one to clear, except the live calibration busy bit; a new event wins over the clear
   logic [5:0] stat_q;
   logic [5:0] stat_d;
   logic [5:0] stat_clr;
   logic       wake_d;

   always_comb begin
      stat_clr = (wr && addr == `OFF_STAT) ? wdata[5:0] : 6'h00;
      stat_d   = stat_q & ~stat_clr;
      stat_d[`ST_OVF0]     = stat_d[`ST_OVF0] | ovf_ev[0];
      stat_d[`ST_OVF1]     = stat_d[`ST_OVF1] | ovf_ev[1];
      stat_d[`ST_CMP0]     = stat_d[`ST_CMP0] | cmp_ev[0];
      stat_d[`ST_CMP1]     = stat_d[`ST_CMP1] | cmp_ev[1];
      stat_d[`ST_CAL_BUSY] = cal_d == CAL_TEST;
      stat_d[`ST_CAL_FAIL] = stat_d[`ST_CAL_FAIL] | cal_fail_set;
      wake_d = |(stat_q[3:0] & wake_en_q);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_q <= 6'h00;
         wake_q <= 1'b0;
      end else begin
         stat_q <= stat_d;
         wake_q <= wake_d;
      end
   end

   // Read port, data one cycle after the strobe
   logic [7:0] rdata_d;

   always_comb begin
      rdata_d = 8'h00;
      if (rd) begin
         unique case (addr)
            `OFF_MODE:    rdata_d = mode_q;
            `OFF_PUCFG:   rdata_d = pucfg_q;
            `OFF_CNT0:    rdata_d = g_ch[0].cnt_q[7:0];
            `OFF_CNT0_B1: rdata_d = g_ch[0].cnt_q[15:8];
            `OFF_CNT0_B2: rdata_d = g_ch[0].cnt_q[23:16];
            `OFF_CNT1:    rdata_d = g_ch[1].cnt_q[7:0];
            `OFF_CNT1_B1: rdata_d = g_ch[1].cnt_q[15:8];
            `OFF_CNT1_B2: rdata_d = g_ch[1].cnt_q[23:16];
            `OFF_THR0:    rdata_d = thr_q[0][7:0];
            `OFF_THR0_B1: rdata_d = thr_q[0][15:8];
            `OFF_THR0_B2: rdata_d = thr_q[0][23:16];
            `OFF_THR1:    rdata_d = thr_q[1][7:0];
            `OFF_THR1_B1: rdata_d = thr_q[1][15:8];
            `OFF_THR1_B2: rdata_d = thr_q[1][23:16];
            `OFF_STAT:    rdata_d = {2'h0, stat_q};
            `OFF_WAKE_EN: rdata_d = {4'h0, wake_en_q};
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         rdata_q <= 8'h00;
      else
         rdata_q <= rdata_d;
   end
endmodule // pulse_counter

// ===== tb/reed_switch_model.sv
// Switch or encoder model that drives the two pulse input pins.
// Assumes the bench commands open or closed and passes the pull-up outputs.
`timescale 1ns/100ps
module reed_switch_model #(
   parameter logic [2:0] MIN_STR = 3'h3
) (
   input  wire logic       form_a,
   input  wire logic       open_zero,
   input  wire logic       open_one,
   input  wire logic       pullup_en,
   input  wire logic [2:0] pullup_str,
   output logic            line_zero,
   output logic            line_one
);
   logic charged;
   assign charged = !form_a || (pullup_en && pullup_str >= MIN_STR);
   assign line_zero = open_zero && charged;
   assign line_one  = open_one && charged;
endmodule // reed_switch_model

// ===== tb/pulse_counter_chk.sv
// Checker: register reads, wake request and pull-up timing of the pulse counter.
// Sees only the top ports; the bind follows the module.
`timescale 1ns/100ps
`include "pulse_counter_regs.svh"
module pulse_counter_chk (
   input wire logic               clk,
   input wire logic               rst,
   input wire logic               rtc_clk,
   input wire logic               pulse_input_zero,
   input wire logic               pulse_input_one,
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic [7:0]         wdata,
   input wire logic               wr,
   input wire logic               rd,
   input wire logic [7:0]         rdata_q,
   input wire logic               wake_q,
   input wire logic               pullup_en_q,
   input wire logic [2:0]         pullup_str_q
);
   logic [7:0] mode_q;
   logic [3:0] wen_q;
   logic       rtc_q;
   logic [3:0] since_q;
   logic       cnt_rd;
   assign cnt_rd = rd && addr >= `OFF_CNT0 && addr < `OFF_THR0;
   // Shadow of writes; counters stay hidden so only zero cases are judged
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_q  <= 8'h00;
         wen_q   <= 4'h0;
         rtc_q   <= 1'b0;
         since_q <= 4'h0;
      end else begin
         if (wr && addr == `OFF_MODE) mode_q <= wdata;
         if (wr && addr == `OFF_WAKE_EN) wen_q <= wdata[3:0];
         rtc_q   <= rtc_clk;
         since_q <= (rtc_clk && !rtc_q) ? 4'h0 : since_q + {3'h0, since_q != 4'hF};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_rd_idle; !$past(rd) |-> rdata_q == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_mode_rb; rd && addr == `OFF_MODE |=> rdata_q == mode_q; endproperty
   a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong");
   property p_off_zero; cnt_rd && mode_q[7:6] == 2'b00 |=> rdata_q == 8'h00; endproperty
   a_off_zero: assert property (p_off_zero) else $error("counter moved while off");
   property p_clear; (wr && addr == `OFF_MODE) ##1 cnt_rd |=> rdata_q == 8'h00; endproperty
   a_clear: assert property (p_clear) else $error("counter not cleared");
   property p_single; rd && addr >= `OFF_CNT1 && addr < `OFF_THR0 && mode_q[7:6] == 2'b01 |=> rdata_q == 8'h00;
   endproperty
   a_single: assert property (p_single) else $error("counter 1 used in single mode");
   property p_cal_rd; rd && addr == `OFF_PUCFG |=> !rdata_q[`PU_CALGO_BIT] && !rdata_q[7]; endproperty
   a_cal_rd: assert property (p_cal_rd) else $error("start bit reads one");
   property p_wen_rb; rd && addr == `OFF_WAKE_EN |=> rdata_q == {4'h0, wen_q}; endproperty
   a_wen_rb: assert property (p_wen_rb) else $error("wake enable readback wrong");
   property p_wake; wake_q |-> (wen_q | $past(wen_q)) != 4'h0; endproperty
   a_wake: assert property (p_wake) else $error("wake without enable");
   property p_pu_str; $rose(pullup_en_q) |-> pullup_str_q != 3'h0; endproperty
   a_pu_str: assert property (p_pu_str) else $error("pull-up on at zero strength");
   property p_pu_rtc; $rose(pullup_en_q) && !$past(wr) && !$past(wr, 2) && !$past(wr, 3) |-> since_q <= 4'h6;
   endproperty
   a_pu_rtc: assert property (p_pu_rtc) else $error("pull-up not on RTC timing");
   c_wake: cover property ($rose(wake_q));
   c_pullup: cover property ($rose(pullup_en_q));
   c_count: cover property (cnt_rd ##1 rdata_q != 8'h00);
endmodule // pulse_counter_chk

bind pulse_counter pulse_counter_chk u_chk (.clk(clk), .rst(rst), .rtc_clk(rtc_clk),
   .pulse_input_zero(pulse_input_zero), .pulse_input_one(pulse_input_one), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata_q(rdata_q), .wake_q(wake_q), .pullup_en_q(pullup_en_q), .pullup_str_q(pullup_str_q));

// ===== tb/pulse_counter_tb.sv
// Testbench: register port, counting modes, pull-up timing and calibration.
// Assumes the pulse counter, its bound checker and the switch model.
`timescale 1ns/100ps
`include "pulse_counter_regs.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module pulse_counter_tb;
   typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   // Fast RTC keeps runs short: one sample period is 64 clocks
   localparam int HOLD = 1280;
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   logic               rtc_clk = 1'b0;
   logic [`ADDR_W-1:0] addr = 4'h0;
   logic [7:0]         wdata = 8'h00;
   logic               wr = 1'b0;
   logic               rd = 1'b0;
   logic               form_a = 1'b0;
   logic               open_zero = 1'b0;
   logic               open_one = 1'b0;
   logic               line_zero;
   logic               line_one;
   logic [7:0]         rdata_q;
   logic               wake_q;
   logic               pullup_en_q;
   logic [2:0]         pullup_str_q;
   logic [7:0]         d;
   logic [23:0]        c0;
   logic [23:0]        c1;
   int                 errors = 0;
   int                 check_count = 0;
   int                 n;
   int                 hi;
   int                 duty8 [4] = '{2, 3, 4, 6};
   logic [1:0]         quad [10] = '{2'h2, 2'h3, 2'h1, 2'h0, 2'h1, 2'h3, 2'h2, 2'h0, 2'h3, 2'h0};
   row_t               rows [8] = '{
      '{`OFF_MODE, 8'hFF, 8'hFF}, '{`OFF_PUCFG, 8'h3F, 8'h3F}, '{`OFF_THR0, 8'hA5, 8'hA5},
      '{4'hD, 8'h5A, 8'h5A}, '{4'h3, 8'hFF, 8'h00}, '{`OFF_CNT1, 8'h77, 8'h00},
      '{`OFF_WAKE_EN, 8'hFF, 8'h0F}, '{`OFF_STAT, 8'hFF, 8'h00}};

   always #20 clk = ~clk;
   always #160 rtc_clk = ~rtc_clk;

   reed_switch_model #(.MIN_STR(3'h3)) sw (.form_a(form_a), .open_zero(open_zero), .open_one(open_one),
      .pullup_en(pullup_en_q), .pullup_str(pullup_str_q), .line_zero(line_zero), .line_one(line_one));
   pulse_counter dut (.clk(clk), .rst(rst), .rtc_clk(rtc_clk), .pulse_input_zero(line_zero),
      .pulse_input_one(line_one), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
      .wake_q(wake_q), .pullup_en_q(pullup_en_q), .pullup_str_q(pullup_str_q));

   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      @(negedge clk);
      v = rdata_q;
   endtask
   // No snapshot: inputs are held still while the six bytes are read
   task automatic rd_cnt();
      logic [7:0] b [6];
      for (int i = 0; i < 6; i++) rd_reg(`OFF_CNT0 + 4'(i), b[i]);
      c0 = {b[2], b[1], b[0]};
      c1 = {b[5], b[4], b[3]};
   endtask
   task automatic lvl(input logic [1:0] s);
      @(posedge clk);
      open_one  <= s[1];
      open_zero <= s[0];
      repeat (HOLD) @(posedge clk);
   endtask
   task automatic wait_pu(input logic v, output int k);
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (pullup_en_q !== v && k < 3000);
      if (k >= 3000) begin
         errors++;
         end_of_test();
      end
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 16; a++) begin
         rd_reg(4'(a), d);
         `CHK("reset value", 8'h00, d)
      end
      foreach (rows[i]) begin
         wr_reg(rows[i].a, rows[i].d);
         rd_reg(rows[i].a, d);
         `CHK("register readback", rows[i].e, d)
      end
      done("registers");
      wr_reg(`OFF_MODE, 8'h40);
      wr_reg(`OFF_THR0, 8'h02);
      wr_reg(`OFF_WAKE_EN, 8'h04);
      lvl(2'h3);
      lvl(2'h0);
      rd_reg(`OFF_STAT, d);
      `CHK("status below threshold", 8'h00, d)
      lvl(2'h1);
      lvl(2'h0);
      rd_reg(`OFF_STAT, d);
      `CHK("status at threshold", 8'h04, d)
      `CHK("wake request", 1'b1, wake_q)
      wr_reg(`OFF_STAT, 8'h04);
      repeat (2) @(negedge clk);
      `CHK("wake cleared", 1'b0, wake_q)
      lvl(2'h1);
      lvl(2'h0);
      rd_reg(`OFF_STAT, d);
      `CHK("one compare event", 8'h00, d)
      rd_cnt();
      `CHK("single counter 0", 24'h000003, c0)
      `CHK("single counter 1", 24'h000000, c1)
      done("single");
      wr_reg(`OFF_MODE, 8'h80);
      lvl(2'h3);
      lvl(2'h0);
      lvl(2'h2);
      lvl(2'h0);
      rd_cnt();
      `CHK("dual counter 0", 24'h000001, c0)
      `CHK("dual counter 1", 24'h000002, c1)
      done("dual");
      wr_reg(`OFF_MODE, 8'hC0);
      foreach (quad[i]) lvl(quad[i]);
      rd_cnt();
      `CHK("clockwise steps", 24'h000004, c0)
      `CHK("counter-clockwise steps", 24'h000004, c1)
      done("quadrature");
      @(posedge clk);
      addr  <= `OFF_MODE;
      wdata <= 8'h00;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      rd    <= 1'b1;
      addr  <= `OFF_CNT0;
      @(posedge clk);
      rd    <= 1'b0;
      @(negedge clk);
      `CHK("counter after mode write", 8'h00, rdata_q)
      lvl(2'h1);
      lvl(2'h0);
      rd_cnt();
      `CHK("counter while off", 24'h000000, c0)
      done("off");
      for (int r = 0; r < 4; r++) begin
         wr_reg(`OFF_MODE, {2'b01, 2'(r), 4'h0});
         wr_reg(`OFF_PUCFG, {6'h01, 2'(r)});
         wait_pu(1'b1, n);
         wait_pu(1'b0, n);
         wait_pu(1'b1, n);
         wait_pu(1'b0, hi);
         wait_pu(1'b1, n);
         `CHK("pull-up high time", 8 * (duty8[r] << r), hi)
         `CHK("sample period", 64 << r, hi + n)
      end
      done("rates");
      wr_reg(`OFF_MODE, 8'h40);
      @(posedge clk);
      form_a    <= 1'b1;
      open_zero <= 1'b1;
      wr_reg(`OFF_PUCFG, 8'h40);
      n = 0;
      do begin
         rd_reg(`OFF_STAT, d);
         n++;
      end while (d[`ST_CAL_BUSY] !== 1'b0 && n < 300);
      `CHK("calibration status", 2'b00, d[`ST_CAL_FAIL:`ST_CAL_BUSY])
      if (n >= 300) begin
         errors++;
         end_of_test();
      end
      rd_reg(`OFF_PUCFG, d);
      `CHK("calibrated strength", 8'h0C, d)
      done("calibration");
      end_of_test();
   end
endmodule // pulse_counter_tb
